// File: logic/ssrx_top.sv
/*
 * Receive sequencer and packet buffer control of a spread-spectrum modem:
 * register port, mode control, preamble search, timeouts, event flags and
 * buffer pointers.
 * Assumes a host on the same clock using one-cycle strobes, and a
 * demodulator that presents one symbol per rising link clock edge.
 */
`timescale 1ns/10ps
`include "ssrx_cfg.svh"
module ssrx_top (
	input  wire logic       sys_clk,       // 125 MHz system clock.
	input  wire logic       rst_n,         // Synchronous reset, active low.
	input  wire logic [7:0] reg_addr,      // Register address.
	input  wire logic [7:0] reg_wdata,     // Register write data.
	input  wire logic       reg_wr,        // Write strobe.
	input  wire logic       reg_rd,        // Read strobe.
	output logic      [7:0] reg_rdata,     // Read data, cycle after strobe.
	input  wire logic       link_clk,      // Symbol clock from demodulator.
	input  wire logic       link_pre,      // Symbol is a preamble symbol.
	input  wire logic       link_hdr,      // Valid header seen this symbol.
	input  wire logic       link_bvld,     // Payload byte present.
	input  wire logic [7:0] link_byte,     // Payload byte.
	input  wire logic       link_end,      // Payload ends with this symbol.
	input  wire logic       link_crc_bad,  // Payload check failed, with end.
	output logic            synth_on,      // Synthesizer enabled.
	output logic            rf_on,         // RF receive blocks enabled.
	output logic            gain_lock      // Receive gain fixed on preamble.
);

	logic              tick;
	logic [12:0]       fld;
	logic [7:0]        mem_rd;
	logic              mem_we;
	logic [7:0]        mem_wa;
	logic [7:0]        mem_wd;

	logic [2:0]        mode_ff, nxt_mode;
	logic [7:0]        ptr_ff, nxt_ptr;
	logic [7:0]        txb_ff, nxt_txb;
	logic [7:0]        rxb_ff, nxt_rxb;
	logic [7:0]        plen_ff, nxt_plen;
	logic [9:0]        win_ff, nxt_win;
	logic [15:0]       prel_ff, nxt_prel;
	logic [15:0]       tmo_ff, nxt_tmo;
	logic              impl_ff, nxt_impl;
	logic [7:0]        flags_ff, nxt_flags;
	logic [7:0]        wptr_ff, nxt_wptr;
	logic [7:0]        start_ff, nxt_start;
	logic [7:0]        cnt_ff, nxt_cnt;
	logic [9:0]        wcnt_ff, nxt_wcnt;
	logic [15:0]       tcnt_ff, nxt_tcnt;
	logic              tdone_ff, nxt_tdone;
	logic [15:0]       pcnt_ff, nxt_pcnt;
	logic [7:0]        rdata_ff, nxt_rdata;
	logic              synth_ff, nxt_synth;
	logic              rf_ff, nxt_rf;
	logic              gain_ff, nxt_gain;
	ssrx_pkg::ssrx_state_t state_ff, nxt_state;

	logic [7:0]        fset;
	logic [7:0]        fclr;
	logic              rx_mode;
	logic              to_stby;
	logic              fifo_ok;
	logic              mode_wr;

	ssrx_link_rx #(
		.W (14)
	) u_link (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pins    ({link_clk, link_pre, link_hdr, link_bvld, link_end, link_crc_bad, link_byte}),
		.tick    (tick),
		.fields  (fld)
	);

	ssrx_buffer #(
		.AW (8),
		.DW (8)
	) u_buf (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clear   (mode_ff == `SSRX_M_SLEEP),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (ptr_ff),
		.rd_data (mem_rd)
	);

	always_comb begin
		nxt_mode  = mode_ff;
		nxt_ptr   = ptr_ff;
		nxt_txb   = txb_ff;
		nxt_rxb   = rxb_ff;
		nxt_plen  = plen_ff;
		nxt_win   = win_ff;
		nxt_prel  = prel_ff;
		nxt_tmo   = tmo_ff;
		nxt_impl  = impl_ff;
		nxt_wptr  = wptr_ff;
		nxt_start = start_ff;
		nxt_cnt   = cnt_ff;
		nxt_wcnt  = wcnt_ff;
		nxt_tcnt  = tcnt_ff;
		nxt_tdone = tdone_ff;
		nxt_pcnt  = pcnt_ff;
		nxt_gain  = gain_ff;
		nxt_state = state_ff;
		nxt_rdata = 8'h00;
		fset      = 8'h00;
		fclr      = 8'h00;
		mem_we    = 1'b0;
		mem_wa    = wptr_ff;
		mem_wd    = fld[7:0];
		to_stby   = 1'b0;
		rx_mode   = (mode_ff == `SSRX_M_RXC) || (mode_ff == `SSRX_M_RXS);
		fifo_ok   = mode_ff != `SSRX_M_SLEEP;
		mode_wr   = reg_wr && (reg_addr == `SSRX_A_MODE);

		// Absolute timer from receive entry, in symbols; zero disables it.
		if (rx_mode && tick && !tdone_ff && (tmo_ff != 16'h0000)) begin
			nxt_tcnt = 16'(tcnt_ff + 16'h0001);
			if (nxt_tcnt == tmo_ff) begin
				nxt_tdone = 1'b1;
				fset[`SSRX_F_TMO] = 1'b1;
				to_stby = mode_ff == `SSRX_M_RXS;
			end
		end

		if (rx_mode && tick) begin
			unique case (state_ff)
				ssrx_pkg::SSRX_SEARCH: begin
					if (fld[12]) begin
						nxt_state = ssrx_pkg::SSRX_PREAM;
						nxt_pcnt  = 16'h0001;
						nxt_gain  = 1'b1;
					end else if (mode_ff == `SSRX_M_RXS) begin
						nxt_wcnt = 10'(wcnt_ff + 10'h001);
						if (nxt_wcnt == win_ff) begin
							fset[`SSRX_F_TMO] = 1'b1;
							to_stby = 1'b1;
						end
					end
				end
				ssrx_pkg::SSRX_PREAM: begin
					if (fld[12]) begin
						nxt_pcnt = 16'(pcnt_ff + 16'h0001);
						if (pcnt_ff >= prel_ff) begin
							nxt_state = ssrx_pkg::SSRX_SEARCH;
							nxt_gain  = 1'b0;
							nxt_wcnt  = 10'h000;
						end
					end else if (impl_ff) begin
						fset[`SSRX_F_HDR] = 1'b1;
						nxt_state = ssrx_pkg::SSRX_PAYLD;
						nxt_start = wptr_ff;
						nxt_cnt   = 8'h00;
					end else begin
						nxt_state = ssrx_pkg::SSRX_HEADER;
					end
				end
				ssrx_pkg::SSRX_HEADER: begin
					if (fld[11]) begin
						fset[`SSRX_F_HDR] = 1'b1;
						nxt_state = ssrx_pkg::SSRX_PAYLD;
						nxt_start = wptr_ff;
						nxt_cnt   = 8'h00;
					end
				end
				ssrx_pkg::SSRX_PAYLD: begin
					if (fld[10]) begin
						mem_we   = 1'b1;
						nxt_wptr = 8'(wptr_ff + 8'h01);
						nxt_cnt  = 8'(cnt_ff + 8'h01);
					end
					if (fld[9]) begin
						fset[`SSRX_F_DONE] = 1'b1;
						fset[`SSRX_F_CRC]  = fld[8];
						nxt_gain  = 1'b0;
						nxt_state = ssrx_pkg::SSRX_SEARCH;
						nxt_wcnt  = 10'h000;
						to_stby   = to_stby || (mode_ff == `SSRX_M_RXS);
					end
				end
				default: begin
					nxt_state = ssrx_pkg::SSRX_SEARCH;
				end
			endcase
		end

		if (to_stby) begin
			nxt_mode = `SSRX_M_STBY;
		end

		if (reg_wr) begin
			unique case (reg_addr)
				`SSRX_A_FIFO: begin
					if (fifo_ok && !mem_we) begin
						mem_we = 1'b1;
						mem_wa = ptr_ff;
						mem_wd = reg_wdata;
						nxt_ptr = 8'(ptr_ff + 8'h01);
					end
				end
				`SSRX_A_MODE: begin
					nxt_mode = reg_wdata[2:0];
				end
				`SSRX_A_PTR:    nxt_ptr  = reg_wdata;
				`SSRX_A_TXB:    nxt_txb  = reg_wdata;
				`SSRX_A_RXB:    nxt_rxb  = reg_wdata;
				`SSRX_A_FLAGS:  fclr     = reg_wdata;
				`SSRX_A_CFG:    nxt_impl = reg_wdata[0];
				`SSRX_A_WIN_HI: nxt_win  = {reg_wdata[1:0], win_ff[7:0]};
				`SSRX_A_WIN_LO: nxt_win  = {win_ff[9:8], reg_wdata};
				`SSRX_A_PRE_HI: nxt_prel = {reg_wdata, prel_ff[7:0]};
				`SSRX_A_PRE_LO: nxt_prel = {prel_ff[15:8], reg_wdata};
				`SSRX_A_PLEN:   nxt_plen = reg_wdata;
				`SSRX_A_TMO_HI: nxt_tmo  = {reg_wdata, tmo_ff[7:0]};
				`SSRX_A_TMO_LO: nxt_tmo  = {tmo_ff[15:8], reg_wdata};
				default: begin
				end
			endcase
		end

		// Entry into receive restarts the search and the absolute timer;
		// reselecting continuous while in it keeps the write pointer.
		if (mode_wr && ((nxt_mode == `SSRX_M_RXS) ||
				((nxt_mode == `SSRX_M_RXC) && (mode_ff != `SSRX_M_RXC)))) begin
			nxt_state = ssrx_pkg::SSRX_SEARCH;
			nxt_wptr  = rxb_ff;
			nxt_wcnt  = 10'h000;
			nxt_tcnt  = 16'h0000;
			nxt_tdone = 1'b0;
			nxt_gain  = 1'b0;
		end
		if ((nxt_mode != `SSRX_M_RXC) && (nxt_mode != `SSRX_M_RXS)) begin
			nxt_state = ssrx_pkg::SSRX_IDLE;
			nxt_gain  = 1'b0;
		end

		if (reg_rd) begin
			unique case (reg_addr)
				`SSRX_A_FIFO: begin
					if (fifo_ok) begin
						nxt_rdata = mem_rd;
						nxt_ptr   = 8'(ptr_ff + 8'h01);
					end
				end
				`SSRX_A_MODE:   nxt_rdata = {5'h00, mode_ff};
				`SSRX_A_PTR:    nxt_rdata = ptr_ff;
				`SSRX_A_TXB:    nxt_rdata = txb_ff;
				`SSRX_A_RXB:    nxt_rdata = rxb_ff;
				`SSRX_A_START:  nxt_rdata = start_ff;
				`SSRX_A_FLAGS:  nxt_rdata = flags_ff;
				`SSRX_A_CNT:    nxt_rdata = cnt_ff;
				`SSRX_A_STAT:   nxt_rdata = {gain_ff, 2'h0, state_ff};
				`SSRX_A_CFG:    nxt_rdata = {7'h00, impl_ff};
				`SSRX_A_WIN_HI: nxt_rdata = {6'h00, win_ff[9:8]};
				`SSRX_A_WIN_LO: nxt_rdata = win_ff[7:0];
				`SSRX_A_PRE_HI: nxt_rdata = prel_ff[15:8];
				`SSRX_A_PRE_LO: nxt_rdata = prel_ff[7:0];
				`SSRX_A_PLEN:   nxt_rdata = plen_ff;
				`SSRX_A_TMO_HI: nxt_rdata = tmo_ff[15:8];
				`SSRX_A_TMO_LO: nxt_rdata = tmo_ff[7:0];
				`SSRX_A_NXTW:   nxt_rdata = wptr_ff;
				`SSRX_A_RXPOS:  nxt_rdata = wptr_ff;
				default:        nxt_rdata = 8'h00;
			endcase
		end

		// A flag raised in the cycle it is cleared stays set.
		nxt_flags = (flags_ff & ~fclr) | fset;
		nxt_synth = (nxt_mode == `SSRX_M_SYNTH) || (nxt_mode == `SSRX_M_RXC) ||
			(nxt_mode == `SSRX_M_RXS);
		nxt_rf    = (nxt_mode == `SSRX_M_RXC) || (nxt_mode == `SSRX_M_RXS);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_ff  <= `SSRX_M_SLEEP;
			ptr_ff   <= 8'h00;
			txb_ff   <= `SSRX_RST_TXB;
			rxb_ff   <= `SSRX_RST_RXB;
			plen_ff  <= `SSRX_RST_PLEN;
			win_ff   <= `SSRX_RST_WIN;
			prel_ff  <= `SSRX_RST_PRE;
			tmo_ff   <= `SSRX_RST_TMO;
			impl_ff  <= 1'b0;
			flags_ff <= 8'h00;
			wptr_ff  <= `SSRX_RST_RXB;
			start_ff <= 8'h00;
			cnt_ff   <= 8'h00;
			wcnt_ff  <= 10'h000;
			tcnt_ff  <= 16'h0000;
			tdone_ff <= 1'b0;
			pcnt_ff  <= 16'h0000;
			rdata_ff <= 8'h00;
			synth_ff <= 1'b0;
			rf_ff    <= 1'b0;
			gain_ff  <= 1'b0;
			state_ff <= ssrx_pkg::SSRX_IDLE;
		end else begin
			mode_ff  <= nxt_mode;
			ptr_ff   <= nxt_ptr;
			txb_ff   <= nxt_txb;
			rxb_ff   <= nxt_rxb;
			plen_ff  <= nxt_plen;
			win_ff   <= nxt_win;
			prel_ff  <= nxt_prel;
			tmo_ff   <= nxt_tmo;
			impl_ff  <= nxt_impl;
			flags_ff <= nxt_flags;
			wptr_ff  <= nxt_wptr;
			start_ff <= nxt_start;
			cnt_ff   <= nxt_cnt;
			wcnt_ff  <= nxt_wcnt;
			tcnt_ff  <= nxt_tcnt;
			tdone_ff <= nxt_tdone;
			pcnt_ff  <= nxt_pcnt;
			rdata_ff <= nxt_rdata;
			synth_ff <= nxt_synth;
			rf_ff    <= nxt_rf;
			gain_ff  <= nxt_gain;
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata = rdata_ff;
	assign synth_on  = synth_ff;
	assign rf_on     = rf_ff;
	assign gain_lock = gain_ff;

endmodule

// File: common/ssrx_cfg.svh
/*
 * Constants of the spread-spectrum receive sequencer: register offsets,
 * field positions, reset values and mode codes.
 * Assumes an 8-bit register port and a 256-byte shared packet buffer.
 */
`ifndef SSRX_CFG_SVH
`define SSRX_CFG_SVH

`define SSRX_A_FIFO      8'h00
`define SSRX_A_MODE      8'h01
`define SSRX_A_PTR       8'h0d
`define SSRX_A_TXB       8'h0e
`define SSRX_A_RXB       8'h0f
`define SSRX_A_START     8'h10
`define SSRX_A_FLAGS     8'h12
`define SSRX_A_CNT       8'h13
`define SSRX_A_STAT      8'h18
`define SSRX_A_CFG       8'h1d
`define SSRX_A_WIN_HI    8'h1e
`define SSRX_A_WIN_LO    8'h1f
`define SSRX_A_PRE_HI    8'h20
`define SSRX_A_PRE_LO    8'h21
`define SSRX_A_PLEN      8'h22
`define SSRX_A_TMO_HI    8'h23
`define SSRX_A_TMO_LO    8'h24
`define SSRX_A_NXTW      8'h25
`define SSRX_A_RXPOS     8'h26

`define SSRX_M_SLEEP     3'h0
`define SSRX_M_STBY      3'h1
`define SSRX_M_SYNTH     3'h4
`define SSRX_M_RXC       3'h5
`define SSRX_M_RXS       3'h6

`define SSRX_F_TMO       7
`define SSRX_F_DONE      6
`define SSRX_F_CRC       5
`define SSRX_F_HDR       4

`define SSRX_RST_TXB     8'h80
`define SSRX_RST_RXB     8'h00
`define SSRX_RST_WIN     10'h005
`define SSRX_RST_PRE     16'h0008
`define SSRX_RST_PLEN    8'h01
`define SSRX_RST_TMO     16'h0000

`endif

// File: common/ssrx_pkg.sv
/*
 * Types of the spread-spectrum receive sequencer.
 * Assumes the constants header for all numeric values other than the state codes.
 */
package ssrx_pkg;

	typedef enum logic [4:0] {
		SSRX_IDLE   = 5'h01,
		SSRX_SEARCH = 5'h02,
		SSRX_PREAM  = 5'h04,
		SSRX_HEADER = 5'h08,
		SSRX_PAYLD  = 5'h10
	} ssrx_state_t;

endpackage

// File: logic/ssrx_buffer.sv
/*
 * Shared packet buffer with an asynchronous read port and a sweeping clear.
 * Assumes the caller arbitrates writers and blocks access while clearing.
 */
`timescale 1ns/10ps
module ssrx_buffer #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 8
) (
	input  wire logic          sys_clk,  // System clock.
	input  wire logic          rst_n,    // Synchronous reset, active low.
	input  wire logic          clear,    // Level: sweep the buffer to zero.
	input  wire logic          wr_en,    // Write enable.
	input  wire logic [AW-1:0] wr_addr,  // Write address.
	input  wire logic [DW-1:0] wr_data,  // Write data.
	input  wire logic [AW-1:0] rd_addr,  // Read address.
	output logic      [DW-1:0] rd_data   // Read data, same cycle.
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [AW-1:0] clr_ptr_ff;
	logic [AW-1:0] nxt_clr_ptr;

	always_comb begin
		nxt_clr_ptr = clear ? AW'(clr_ptr_ff + 1'b1) : '0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clr_ptr_ff <= '0;
		end else begin
			clr_ptr_ff <= nxt_clr_ptr;
		end
	end

	// The sweep keeps running for as long as clear is held.
	always_ff @(posedge sys_clk) begin
		if (clear) begin
			mem[clr_ptr_ff] <= '0;
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule

// File: logic/ssrx_link_rx.sv
/*
 * Link sampler: brings the demodulator pins into the system clock domain
 * and emits one tick per rising link clock edge with the sampled fields.
 * Assumes the far end changes its pins away from the rising link edge.
 */
`timescale 1ns/10ps
module ssrx_link_rx #(
	parameter int unsigned W = 14
) (
	input  wire logic          sys_clk,   // System clock.
	input  wire logic          rst_n,     // Synchronous reset, active low.
	input  wire logic [W-1:0]  pins,      // Link clock in top bit, fields below.
	output logic               tick,      // One-cycle pulse per symbol.
	output logic      [W-2:0]  fields     // Fields sampled at the tick.
);

	logic [W-1:0] sync1_ff;
	logic [W-1:0] sync2_ff;
	logic         clk_old_ff;
	logic [W-1:0] nxt_sync1;
	logic [W-1:0] nxt_sync2;
	logic         nxt_clk_old;

	always_comb begin
		nxt_sync1   = pins;
		nxt_sync2   = sync1_ff;
		nxt_clk_old = sync2_ff[W-1];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_ff   <= '0;
			sync2_ff   <= '0;
			clk_old_ff <= 1'b0;
		end else begin
			sync1_ff   <= nxt_sync1;
			sync2_ff   <= nxt_sync2;
			clk_old_ff <= nxt_clk_old;
		end
	end

	assign tick   = sync2_ff[W-1] & ~clk_old_ff;
	assign fields = sync2_ff[W-2:0];

endmodule

// File: verif/ssrx_demod_model.sv
/* Behavioural demodulator that drives the link pins of the receive sequencer.
 * Assumes the bench calls its tasks; the link clock stands still between calls. */
`timescale 1ns/10ps
module ssrx_demod_model (
	output logic       link_clk,     // Symbol clock, 160 ns per symbol.
	output logic       link_pre,     // Preamble symbol.
	output logic       link_hdr,     // Valid header symbol.
	output logic       link_bvld,    // Payload byte present.
	output logic [7:0] link_byte,    // Payload byte.
	output logic       link_end,     // Last payload symbol.
	output logic       link_crc_bad  // Payload check failed.
);
	initial begin
		{link_clk, link_pre, link_hdr, link_bvld, link_end, link_crc_bad} = 6'h00;
		link_byte = 8'h5a;
	end

	// Fields change half a symbol away from the rising edge and are scrambled afterwards.
	task automatic sym(input logic p, h, v, e, c, input logic [7:0] b);
		{link_pre, link_hdr, link_bvld, link_end, link_crc_bad} = {p, h, v, e, c};
		link_byte = v ? b : ~link_byte;
		#80 link_clk = 1'b1;
		#80 link_clk = 1'b0;
		{link_pre, link_hdr, link_bvld, link_end, link_crc_bad} = 5'h00;
		link_byte = ~link_byte;
	endtask

	task automatic quiet(input int n);
		repeat (n) sym(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	task automatic pre(input int n);
		repeat (n) sym(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	task automatic frame(input int np, nb, input logic impl, c, input logic [7:0] b0);
		pre(np);
		quiet(1);
		if (!impl) begin
			sym(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		end
		for (int i = 0; i < nb; i++) begin
			sym(1'b0, 1'b0, 1'b1, i == nb - 1, c && i == nb - 1, b0 + i[7:0]);
		end
	endtask
endmodule

// File: verif/ssrx_top_assertions.sv
/* Port-level checks of the receive sequencer top.
 * Assumes the bind below and a host that selects modes through the mode register. */
`timescale 1ns/10ps
`include "ssrx_cfg.svh"
module ssrx_top_assertions (
	input wire logic       sys_clk,    // System clock.
	input wire logic       rst_n,      // Synchronous reset, active low.
	input wire logic [7:0] reg_addr,   // Register address.
	input wire logic [7:0] reg_wdata,  // Register write data.
	input wire logic       reg_wr,     // Write strobe.
	input wire logic       reg_rd,     // Read strobe.
	input wire logic [7:0] reg_rdata,  // Read data.
	input wire logic       link_pre,   // Preamble symbol.
	input wire logic       synth_on,   // Synthesizer enabled.
	input wire logic       rf_on,      // RF receive enabled.
	input wire logic       gain_lock   // Gain fixed.
);
	logic [2:0] mode_ff;
	logic [2:0] nxt_mode;

	// Last mode the host selected; automatic returns are not tracked.
	always_comb begin
		nxt_mode = mode_ff;
		if (reg_wr && reg_addr == `SSRX_A_MODE) begin
			nxt_mode = reg_wdata[2:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		mode_ff <= rst_n ? nxt_mode : `SSRX_M_SLEEP;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data without a read strobe");
	rf_synth_a: assert property (rf_on |-> synth_on)
		else $error("rf on without synthesizer");
	host_start_a: assert property (($rose(rf_on) || $rose(synth_on)) |->
		$past(reg_wr && reg_addr == `SSRX_A_MODE)) else $error("receive entered without mode write");
	auto_stop_a: assert property (($fell(rf_on) && !$past(reg_wr)) |-> !synth_on)
		else $error("automatic stop left synthesizer on");
	cont_stays_a: assert property ((rf_on && mode_ff == `SSRX_M_RXC && !reg_wr) |=> rf_on)
		else $error("continuous receive stopped on its own");
	gain_pre_a: assert property ($rose(gain_lock) |-> $past(link_pre, 2) && rf_on)
		else $error("gain fixed without a preamble symbol");
	gain_idle_a: assert property ((!rf_on && !$past(rf_on)) |-> !gain_lock)
		else $error("gain fixed outside receive");
	sleep_read_a: assert property ((reg_rd && reg_addr == `SSRX_A_FIFO &&
		mode_ff == `SSRX_M_SLEEP) |=> reg_rdata == 8'h00) else $error("buffer readable in sleep");

	cover property ($rose(gain_lock));
	cover property ($fell(rf_on) && !$past(reg_wr));
	cover property (reg_rd && reg_addr == `SSRX_A_FIFO && mode_ff == `SSRX_M_SLEEP);
endmodule

bind ssrx_top ssrx_top_assertions u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .link_pre, .synth_on, .rf_on, .gain_lock);

// File: verif/test_spread_spectrum_rx_sequencer.sv
/* Self-checking bench of the receive sequencer with a demodulator model.
 * Assumes a 125 MHz clock and read data one cycle after the read strobe. */
`timescale 1ns/10ps
`include "ssrx_cfg.svh"
module test_spread_spectrum_rx_sequencer;
	logic       sys_clk = 1'b0;
	logic       rst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       link_clk, link_pre, link_hdr, link_bvld, link_end, link_crc_bad;
	logic [7:0] link_byte;
	logic       synth_on, rf_on, gain_lock;
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;

	always #4 sys_clk = ~sys_clk;

	ssrx_top DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.link_clk, .link_pre, .link_hdr, .link_bvld, .link_byte, .link_end, .link_crc_bad,
		.synth_on, .rf_on, .gain_lock);
	ssrx_demod_model lnk (.link_clk, .link_pre, .link_hdr, .link_bvld, .link_byte,
		.link_end, .link_crc_bad);

	task automatic end_of_test();
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("register %h", a), reg_rdata, exp);
	endtask

	// Reads n buffer bytes from the current access pointer, expecting b0 counting up.
	task automatic burst(input logic [7:0] b0, input int n);
		for (int i = 0; i < n; i++) begin
			rd(`SSRX_A_FIFO, b0 + i[7:0]);
		end
	endtask

	// Waits past the launching edge so that freshly registered levels are seen.
	task automatic pins(input logic s, r);
		#1;
		chk("synth_on", {7'h00, synth_on}, {7'h00, s});
		chk("rf_on", {7'h00, rf_on}, {7'h00, r});
	endtask

	initial begin
		rst_n <= 1'b0;
		reg_addr <= 8'h00;
		reg_wdata <= 8'h00;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`SSRX_A_TXB, 8'h80);
		rd(`SSRX_A_RXB, 8'h00);
		rd(`SSRX_A_WIN_LO, 8'h05);
		wr(`SSRX_A_PTR, 8'h10);
		wr(`SSRX_A_FIFO, 8'haa);
		rd(`SSRX_A_PTR, 8'h10);
		rd(`SSRX_A_FIFO, 8'h00);
		repeat (300) @(posedge sys_clk);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_STBY});
		wr(`SSRX_A_PLEN, 8'h03);
		rd(`SSRX_A_PLEN, 8'h03);
		wr(`SSRX_A_PTR, 8'h80);
		for (int i = 0; i < 3; i++) begin
			wr(`SSRX_A_FIFO, 8'hc0 + i[7:0]);
		end
		rd(`SSRX_A_PTR, 8'h83);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_SYNTH});
		pins(1'b1, 1'b0);
		wr(`SSRX_A_PTR, 8'h80);
		burst(8'hc0, 3);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_SLEEP});
		repeat (300) @(posedge sys_clk);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_STBY});
		wr(`SSRX_A_PTR, 8'h80);
		rd(`SSRX_A_FIFO, 8'h00);
		wr(`SSRX_A_PTR, 8'h00);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_RXS});
		lnk.quiet(4);
		pins(1'b1, 1'b1);
		lnk.quiet(1);
		pins(1'b0, 1'b0);
		rd(`SSRX_A_FLAGS, 8'h80);
		rd(`SSRX_A_MODE, 8'h01);
		wr(`SSRX_A_FLAGS, 8'hff);
		rd(`SSRX_A_FLAGS, 8'h00);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_RXS});
		lnk.frame(3, 4, 1'b0, 1'b1, 8'h30);
		pins(1'b0, 1'b0);
		rd(`SSRX_A_FLAGS, 8'h70);
		rd(`SSRX_A_CNT, 8'h04);
		rd(`SSRX_A_NXTW, 8'h04);
		rd(`SSRX_A_RXPOS, 8'h04);
		rd(`SSRX_A_START, 8'h00);
		wr(`SSRX_A_PTR, 8'h00);
		burst(8'h30, 4);
		rd(`SSRX_A_FLAGS, 8'h70);
		wr(`SSRX_A_FLAGS, 8'hff);
		wr(`SSRX_A_RXB, 8'hfe);
		wr(`SSRX_A_CFG, 8'h01);
		wr(`SSRX_A_PRE_LO, 8'h04);
		wr(`SSRX_A_TMO_LO, 8'h0e);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_RXC});
		lnk.frame(2, 2, 1'b1, 1'b0, 8'h50);
		rd(`SSRX_A_FLAGS, 8'h50);
		rd(`SSRX_A_START, 8'hfe);
		rd(`SSRX_A_NXTW, 8'h00);
		wr(`SSRX_A_FLAGS, 8'hff);
		lnk.frame(2, 3, 1'b1, 1'b0, 8'h60);
		pins(1'b1, 1'b1);
		rd(`SSRX_A_START, 8'h00);
		rd(`SSRX_A_CNT, 8'h03);
		wr(`SSRX_A_PTR, 8'hfe);
		burst(8'h50, 2);
		burst(8'h60, 3);
		lnk.quiet(2);
		rd(`SSRX_A_FLAGS, 8'h50);
		lnk.quiet(1);
		rd(`SSRX_A_FLAGS, 8'hd0);
		pins(1'b1, 1'b1);
		wr(`SSRX_A_FLAGS, 8'hff);
		rd(`SSRX_A_FLAGS, 8'h00);
		lnk.pre(4);
		rd(`SSRX_A_STAT, 8'h84);
		chk("gain_lock", {7'h00, gain_lock}, 8'h01);
		lnk.pre(1);
		rd(`SSRX_A_STAT, 8'h02);
		chk("gain_lock", {7'h00, gain_lock}, 8'h00);
		rd(`SSRX_A_FLAGS, 8'h00);
		wr(`SSRX_A_MODE, {5'h00, `SSRX_M_STBY});
		end_of_test();
	end
endmodule
